// ===== scr_cfg.svh
// Purpose: Constants for the config register bank, registers 4 to 7
// Assumes: 32-bit words, select code in the four low bits
// Notes:   Lock counts are in phase detector cycles
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH
// ==========================================================
// Register select codes
`define SCR_SEL_R0       4'h0
`define SCR_SEL_R4       4'h4
`define SCR_SEL_R5       4'h5
`define SCR_SEL_R6       4'h6
`define SCR_SEL_R7       4'h7
// ==========================================================
// Register 4 fields
`define SCR_R4_MUX_HI    29
`define SCR_R4_MUX_LO    27
`define SCR_R4_DBL       26
`define SCR_R4_HALF      25
`define SCR_R4_DBUF      14
`define SCR_R4_LEVEL     8
`define SCR_R4_POL       7
`define SCR_R4_PDOWN     6
`define SCR_R4_TRI       5
`define SCR_R4_CRST      4
// ==========================================================
// Register 6 fields
`define SCR_R6_GBLEED    30
`define SCR_R6_NBLEED    29
`define SCR_R6_FBSEL     24
`define SCR_R6_DIV_HI    23
`define SCR_R6_DIV_LO    21
`define SCR_R6_MUTE      11
`define SCR_R6_OUTB_DIS  10
`define SCR_R6_OUTA_EN   6
`define SCR_R6_PWR_HI    5
`define SCR_R6_PWR_LO    4
// ==========================================================
// Register 7 fields
`define SCR_R7_EDGE      27
`define SCR_R7_SYNC      25
`define SCR_R7_LDC_HI    9
`define SCR_R7_LDC_LO    8
// ==========================================================
// Reset values and lock counts
`define SCR_REG_RESET    32'h0000_0000
`define SCR_LOCK_CNT0    16'h0400
`define SCR_LOCK_CNT1    16'h0800
`define SCR_LOCK_CNT2    16'h1000
`define SCR_LOCK_CNT3    16'h2000
`endif

// ===== scr_host.sv
// Purpose: Host model writing words on the serial pins
// Assumes: Called from the bench at a falling clk edge
// Notes:   Data line inverted once its hold has passed
`timescale 1ns/1ns
`default_nettype none
module scr_host
(
  input  wire logic clk,
  output var  logic ser_clk,
  output var  logic ser_data,
  output var  logic load_strobe
);
  // ======
  // Serial writer
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b1;
  end
  // Four clk per phase clears the pin synchronisers
  task automatic write_word(input logic [31:0] w);
    load_strobe = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      ser_data = w[i];
      repeat (4) @(negedge clk);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
      ser_data = ~w[i];
    end
    repeat (4) @(negedge clk);
    load_strobe = 1'b1;
    repeat (16) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== scr_pkg.sv
// Purpose: Types for the config register bank
// Assumes: Constants live in scr_cfg.svh
// Notes:   Control bundle is registered in the top module
package scr_pkg;
  typedef struct packed {
    logic [2:0] probe_mux_sel;
    logic       probe_level_3v3;
    logic       pd_positive;
    logic       pump_hiz;
    logic       counters_reset;
    logic       vco_power_down;
    logic       bleed_on;
    logic       negative_bleed_en;
    logic       feedback_from_vco;
    logic [2:0] out_div_sel;
    logic       out_stage_supply;
    logic       outa_on;
    logic       outb_on;
    logic [1:0] outa_power_level;
  } scr_ctrl_type;
endpackage

// ===== scr_regs.sv
// Purpose: Serial-loaded registers 4 to 7 and their control logic
// Assumes: Serial pins and reference are slow against clk
// Notes:   Ref edges are seen after the pin synchroniser delay
`include "scr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE_01] Select codes 4, 6, 7 route words
// [RULE_02] Host writes zeros in register 4 top bits
// [RULE_03] Host avoids divider probes during register 0 writes
// [RULE_04] Doubler off: falling edges; on: both edges
// [RULE_05] Halver adds toggle for 50% duty reference
// [RULE_06] Ten-bit R counter divides 1 to 1023
// [RULE_07] Register 4 bit double-buffers divider select
// [RULE_08] Probe level: 0 is 1.8 V, 1 is 3.3 V
// [RULE_09] Polarity bit: 1 positive, 0 negative
// [RULE_10] Power-down stops loop, keeps registers, accepts writes
// [RULE_11] Pump tristate bit puts pump high impedance
// [RULE_12] Counter reset bit holds N, R, band select
// [RULE_13] Host writes register 5 with fixed word
// [RULE_14] Gated bleed keeps bleed off until lock
// [RULE_15] Host controls negative bleed within its limits
// [RULE_16] Feedback select: 1 oscillator, 0 divider chain
// [RULE_17] Divider select bits pick output divider ratio
// [RULE_18] Mute-until-lock cuts output supply before lock
// [RULE_19] Output B bit is active low enable
// [RULE_20] Output A enable bit and power field
// [RULE_21] Load sync aligns load to chosen ref edge
// [RULE_22] Lock count field sets consecutive cycles needed
// [RULE_23] Double-buffered fields apply on register 0 write
// [RULE_24] Word shifted MSB first, latched on load rise
module scr_regs
#(
  parameter int RW = 10
)
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 ser_clk,
  input  wire logic                 ser_data,
  input  wire logic                 load_strobe,
  input  wire logic                 ref_in,
  input  wire logic [RW-1:0]        r_count_ratio,
  input  wire logic                 pd_cycle_ok,
  input  wire logic                 pd_cycle_bad,
  output logic                      pd_ref_clk,
  output logic                      lock_detect,
  output logic                      reg0_written,
  output scr_pkg::scr_ctrl_type     ctrl
);
  // ==========================================================
  // Pin synchronisers
  localparam int NP = 4;
  // Load pin idles high; clearing it here would fake a load rise
  localparam logic [NP-1:0] PIN_IDLE = 4'h4;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_s1_q;
  logic [NP-1:0] pin_s2_q;
  logic [NP-1:0] pin_s3_q;
  assign pin_raw = {ref_in, load_strobe, ser_data, ser_clk};
  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          pin_s1_q[g] <= PIN_IDLE[g];
          pin_s2_q[g] <= PIN_IDLE[g];
          pin_s3_q[g] <= PIN_IDLE[g];
        end
        else
        begin
          pin_s1_q[g] <= pin_raw[g];
          pin_s2_q[g] <= pin_s1_q[g];
          pin_s3_q[g] <= pin_s2_q[g];
        end
      end
    end
  endgenerate
  logic sclk_rise;
  logic sdata;
  logic le_low;
  logic le_rise;
  logic ref_rise;
  logic ref_fall;
  assign sclk_rise = pin_s2_q[0] & ~pin_s3_q[0];
  assign sdata     = pin_s3_q[1];
  assign le_low    = ~pin_s3_q[2];
  assign le_rise   = pin_s2_q[2] & ~pin_s3_q[2];
  assign ref_rise  = pin_s2_q[3] & ~pin_s3_q[3];
  assign ref_fall  = ~pin_s2_q[3] & pin_s3_q[3];
  // ==========================================================
  // Serial shift register
  logic [31:0] shift_q;
  always_ff @(posedge clk)
  begin
    if (reset)
      shift_q <= 32'h0000_0000;
    else if (sclk_rise && le_low)
      shift_q <= {shift_q[30:0], sdata}; // RULE_24
  end
  // ==========================================================
  // Load enable, optionally held for a reference edge
  logic [31:0] reg4_q;
  logic [31:0] reg5_q;
  logic [31:0] reg6_q;
  logic [31:0] reg7_q;
  logic [31:0] word_q;
  logic        pend_q;
  logic        sync_on;
  logic        sync_edge;
  logic        commit;
  logic [31:0] cword;
  assign sync_on   = reg7_q[`SCR_R7_SYNC];
  // Edge select only counts while sync is on; 1 picks rising
  assign sync_edge = reg7_q[`SCR_R7_EDGE] ? ref_rise : ref_fall;
  assign commit    = sync_on ? (pend_q && sync_edge)
                             : le_rise; // RULE_21
  assign cword     = sync_on ? word_q : shift_q;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pend_q <= 1'b0;
      word_q <= 32'h0000_0000;
    end
    else if (le_rise && sync_on)
    begin
      pend_q <= 1'b1; // RULE_21
      word_q <= shift_q; // RULE_24
    end
    else if (commit)
      pend_q <= 1'b0;
  end
  function automatic logic hit(input logic [31:0] w,
                               input logic [3:0]  sel);
    hit = (w[3:0] == sel);
  endfunction
  // ==========================================================
  // Register file; power-down never blocks loading
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg4_q <= `SCR_REG_RESET;
      reg5_q <= `SCR_REG_RESET;
      reg6_q <= `SCR_REG_RESET;
      reg7_q <= `SCR_REG_RESET;
    end
    else if (commit)
    begin
      if (hit(cword, `SCR_SEL_R4))
        reg4_q <= cword; // RULE_01 RULE_10
      if (hit(cword, `SCR_SEL_R5))
        reg5_q <= cword;
      if (hit(cword, `SCR_SEL_R6))
        reg6_q <= cword; // RULE_01
      if (hit(cword, `SCR_SEL_R7))
        reg7_q <= cword; // RULE_01
    end
  end
  // ==========================================================
  // Divider select double buffer
  logic [2:0] div_act_q;
  logic       r0_hit;
  logic       r0_q;
  assign r0_hit = commit && hit(cword, `SCR_SEL_R0);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      div_act_q <= 3'h0;
      r0_q      <= 1'b0;
    end
    else
    begin
      r0_q <= r0_hit;
      if (!reg4_q[`SCR_R4_DBUF])
        div_act_q <= reg6_q[`SCR_R6_DIV_HI:`SCR_R6_DIV_LO]; // RULE_07
      else if (r0_hit)
        div_act_q <= reg6_q[`SCR_R6_DIV_HI:`SCR_R6_DIV_LO]; // RULE_23
    end
  end
  assign reg0_written = r0_q;
  // ==========================================================
  // Reference path: doubler, R counter, halver
  logic          pdown;
  logic          crst;
  logic          ref_evt;
  logic [RW-1:0] rcnt_q;
  logic          rout;
  logic          half_q;
  logic          rpulse_q;
  assign pdown   = reg4_q[`SCR_R4_PDOWN];
  assign crst    = reg4_q[`SCR_R4_CRST];
  assign ref_evt = reg4_q[`SCR_R4_DBL] ? (ref_rise | ref_fall)
                                       : ref_fall; // RULE_04
  // A ratio of zero is treated as one so the counter never stalls
  assign rout    = ref_evt &&
                   (rcnt_q + RW'(1) >= r_count_ratio); // RULE_06
  always_ff @(posedge clk)
  begin
    if (reset || crst || pdown)
    begin
      rcnt_q   <= '0; // RULE_12 RULE_10
      half_q   <= 1'b0;
      rpulse_q <= 1'b0;
    end
    else
    begin
      rpulse_q <= rout;
      if (rout)
      begin
        rcnt_q <= '0; // RULE_06
        half_q <= ~half_q; // RULE_05
      end
      else if (ref_evt)
        rcnt_q <= rcnt_q + RW'(1);
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      pd_ref_clk <= 1'b0;
    else if (reg4_q[`SCR_R4_HALF])
      pd_ref_clk <= half_q; // RULE_05
    else
      pd_ref_clk <= rpulse_q;
  end
  // ==========================================================
  // Lock detector on phase detector cycle verdicts
  logic [15:0] lcnt_q;
  logic [15:0] lneed;
  logic        lock_q;
  always_comb
  begin
    unique case (reg7_q[`SCR_R7_LDC_HI:`SCR_R7_LDC_LO]) // RULE_22
      2'h0: lneed = `SCR_LOCK_CNT0;
      2'h1: lneed = `SCR_LOCK_CNT1;
      2'h2: lneed = `SCR_LOCK_CNT2;
      2'h3: lneed = `SCR_LOCK_CNT3;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (reset || pdown || crst)
    begin
      lcnt_q <= 16'h0000; // RULE_10
      lock_q <= 1'b0;
    end
    else if (pd_cycle_bad)
    begin
      lcnt_q <= 16'h0000;
      lock_q <= 1'b0;
    end
    else if (pd_cycle_ok && !lock_q)
    begin
      if (lcnt_q + 16'h0001 >= lneed)
        lock_q <= 1'b1; // RULE_22
      else
        lcnt_q <= lcnt_q + 16'h0001;
    end
  end
  assign lock_detect = lock_q;
  // ==========================================================
  // Registered control outputs
  scr_pkg::scr_ctrl_type ctrl_d;
  scr_pkg::scr_ctrl_type ctrl_q;
  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.probe_mux_sel     = reg4_q[`SCR_R4_MUX_HI:`SCR_R4_MUX_LO];
    ctrl_d.probe_level_3v3   = reg4_q[`SCR_R4_LEVEL]; // RULE_08
    ctrl_d.pd_positive       = reg4_q[`SCR_R4_POL]; // RULE_09
    ctrl_d.pump_hiz          = reg4_q[`SCR_R4_TRI] | pdown; // RULE_11
    ctrl_d.counters_reset    = crst | pdown; // RULE_12
    ctrl_d.vco_power_down    = pdown; // RULE_10
    ctrl_d.bleed_on          = ~reg6_q[`SCR_R6_GBLEED] | lock_q; // RULE_14
    ctrl_d.negative_bleed_en = reg6_q[`SCR_R6_NBLEED];
    ctrl_d.feedback_from_vco = reg6_q[`SCR_R6_FBSEL]; // RULE_16
    ctrl_d.out_div_sel       = div_act_q; // RULE_17
    ctrl_d.out_stage_supply  = ~pdown &
                  (~reg6_q[`SCR_R6_MUTE] | lock_q); // RULE_18
    ctrl_d.outb_on = ~reg6_q[`SCR_R6_OUTB_DIS] & ~pdown; // RULE_19
    ctrl_d.outa_on = reg6_q[`SCR_R6_OUTA_EN] & ~pdown; // RULE_20
    ctrl_d.outa_power_level =
      reg6_q[`SCR_R6_PWR_HI:`SCR_R6_PWR_LO]; // RULE_20
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_q <= '0;
    else
      ctrl_q <= ctrl_d;
  end
  assign ctrl = ctrl_q;
endmodule
`default_nettype wire

// ===== scr_regs_asserts.sv
// Purpose: Port checker for scr_regs
// Assumes: One clock, synchronous reset
// Notes:   Lock count floor uses the smallest count
`timescale 1ns/1ns
`default_nettype none
module scr_regs_asserts
#(
  parameter int RW = 10
)
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  ser_clk,
  input wire logic                  ser_data,
  input wire logic                  load_strobe,
  input wire logic                  ref_in,
  input wire logic [RW-1:0]         r_count_ratio,
  input wire logic                  pd_cycle_ok,
  input wire logic                  pd_cycle_bad,
  input wire logic                  pd_ref_clk,
  input wire logic                  lock_detect,
  input wire logic                  reg0_written,
  input wire scr_pkg::scr_ctrl_type ctrl
);
  // ======
  // Properties
  localparam int MIN_OK = 1024;
  int ok_cnt;
  // Never cleared by power-down, so it only overestimates
  always_ff @(posedge clk)
  begin
    if (reset || pd_cycle_bad)
      ok_cnt <= 0;
    else if (pd_cycle_ok && ok_cnt < 9000)
      ok_cnt <= ok_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_pdown_pump:
    assert property (ctrl.vco_power_down |->
      ctrl.pump_hiz && ctrl.counters_reset)
    else $error("Pump or counters live in power-down");
  chk_pdown_outs:
    assert property (ctrl.vco_power_down |-> !(ctrl.outa_on || ctrl.outb_on ||
      ctrl.out_stage_supply)) else $error("Output live in power-down");
  chk_crst_lock:
    assert property (ctrl.counters_reset [*2] |-> !lock_detect)
    else $error("Lock held in counter reset");
  chk_bleed_gate:
    assert property ($past(lock_detect) |-> ctrl.bleed_on)
    else $error("Bleed off while locked");
  chk_mute_lock:
    assert property ($past(lock_detect) && !ctrl.vco_power_down |->
      ctrl.out_stage_supply) else $error("Output muted while locked");
  chk_bad_clear:
    assert property (pd_cycle_bad |=> !lock_detect)
    else $error("Lock kept after bad cycle");
  chk_lock_count:
    assert property ($rose(lock_detect) |-> ok_cnt >= MIN_OK)
    else $error("Lock before count reached");
  chk_reg0_pulse:
    assert property (reg0_written |=> !reg0_written)
    else $error("Register 0 pulse too long");
  chk_ctrl_quiet:
    assert property (!load_strobe ##1 !load_strobe |->
      $stable({ctrl.probe_mux_sel, ctrl.out_div_sel,
      ctrl.feedback_from_vco})) else $error("Ctrl moved in shift");
  cover property ($rose(lock_detect));
  cover property (reg0_written);
  cover property (ctrl.vco_power_down);
endmodule
`default_nettype wire

// ===== tb_scr_regs.sv
// Purpose: Self-checking bench for scr_regs
// Assumes: Host model drives the serial pins
// Notes:   Reference toggles every 5 clk while running
`timescale 1ns/1ns
`default_nettype none
module tb_scr_regs;
  // ======
  // Bench
  logic                  clk = 1'b0;
  logic                  reset;
  logic                  ref_in = 1'b0;
  logic                  ref_run = 1'b1;
  logic                  ok;
  logic                  bad;
  logic                  pr_q = 1'b0;
  logic [9:0]            ratio;
  logic                  ser_clk, ser_data, load_strobe;
  logic                  pd_ref_clk, lock_detect, reg0_written;
  scr_pkg::scr_ctrl_type ctrl;
  int                    mismatches = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;
  int                    rises = 0;
  int                    r0_cnt = 0;
  int                    n;
  scr_host i_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));
  scr_regs i_dut (.clk(clk), .reset(reset), .ser_clk(ser_clk),
    .ser_data(ser_data), .load_strobe(load_strobe), .ref_in(ref_in),
    .r_count_ratio(ratio), .pd_cycle_ok(ok), .pd_cycle_bad(bad),
    .pd_ref_clk(pd_ref_clk), .lock_detect(lock_detect),
    .reg0_written(reg0_written), .ctrl(ctrl));
  always #50 clk = ~clk;
  always
  begin
    repeat (5) @(negedge clk);
    if (ref_run)
      ref_in = ~ref_in;
  end
  // Outputs are counted at the falling edge, where they have settled
  always @(negedge clk)
  begin
    cycles++;
    pr_q <= pd_ref_clk;
    if (pd_ref_clk === 1'b1 && pr_q !== 1'b1)
      rises++;
    if (reg0_written === 1'b1)
      r0_cnt++;
    if (cycles == 40000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g)
    begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic oks(input int k);
    repeat (k)
    begin
      ok = 1'b1;
      @(negedge clk);
      ok = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic t_reg4();
    i_host.write_word(32'h2800_0184);
    chk(3'h5, ctrl.probe_mux_sel);
    chk(2'h3, {ctrl.probe_level_3v3, ctrl.pd_positive});
    i_host.write_word(32'hffff_fff3);
    i_host.write_word(32'h0080_0025);
    chk(3'h5, ctrl.probe_mux_sel);
    i_host.write_word(32'h2800_01b4);
    chk(2'h3, {ctrl.pump_hiz, ctrl.counters_reset});
    i_host.write_word(32'h2800_01c4);
    chk(6'h38, {ctrl.vco_power_down, ctrl.pump_hiz, ctrl.counters_reset,
      ctrl.outa_on, ctrl.outb_on, ctrl.out_stage_supply});
    i_host.write_word(32'h2800_0184);
    chk(4'h5, {ctrl.vco_power_down, ctrl.probe_mux_sel});
    $display("t_reg4 done");
  endtask
  task automatic t_reg6();
    i_host.write_word(32'h35a0_0066);
    chk(4'hd, {ctrl.feedback_from_vco, ctrl.out_div_sel});
    chk(4'he, {ctrl.outa_on, ctrl.outb_on,
      ctrl.outa_power_level});
    chk(3'h7, {ctrl.negative_bleed_en, ctrl.bleed_on,
      ctrl.out_stage_supply});
    i_host.write_word(32'h54a0_0c06);
    chk(6'h0, {ctrl.outa_on, ctrl.outb_on, ctrl.negative_bleed_en,
      ctrl.feedback_from_vco,
      ctrl.bleed_on, ctrl.out_stage_supply});
    $display("t_reg6 done");
  endtask
  task automatic t_dbuf();
    i_host.write_word(32'h0000_4004);
    i_host.write_word(32'h5460_0c06);
    chk(3'h5, ctrl.out_div_sel);
    n = r0_cnt;
    i_host.write_word(32'h0000_0000);
    chk(n + 1, r0_cnt);
    chk(3'h3, ctrl.out_div_sel);
    $display("t_dbuf done");
  endtask
  task automatic t_lock();
    for (int k = 0; k < 2; k++)
    begin
      i_host.write_word(32'h0400_0007 | (k << 8));
      oks((1024 << k) - 1);
      repeat (3) @(negedge clk);
      chk(1'b0, lock_detect);
      oks(1);
      repeat (3) @(negedge clk);
      chk(3'h7, {lock_detect, ctrl.bleed_on,
        ctrl.out_stage_supply});
      bad = 1'b1;
      @(negedge clk);
      bad = 1'b0;
      repeat (3) @(negedge clk);
      chk(2'h0, {lock_detect, ctrl.bleed_on});
    end
    $display("t_lock done");
  endtask
  task automatic t_ref();
    logic [31:0] w [4] = '{32'h4, 32'h0400_0004, 32'h0200_0004, 32'h4};
    int e [4] = '{20, 40, 10, 60};
    for (int i = 0; i < 4; i++)
    begin
      ratio = (i == 3) ? 10'h001 : 10'h003;
      i_host.write_word(w[i]);
      rises = 0;
      repeat (600) @(negedge clk);
      chk(1'b1, rises >= e[i] - 1 &&
        rises <= e[i] + 1);
    end
    $display("t_ref done");
  endtask
  task automatic t_sync();
    i_host.write_word(32'h0e00_0007);
    ref_run = 1'b0;
    i_host.write_word(32'h1000_0004);
    chk(3'h0, ctrl.probe_mux_sel);
    ref_run = 1'b1;
    repeat (30) @(negedge clk);
    chk(3'h2, ctrl.probe_mux_sel);
    // Falling-edge sync: park the reference high, then release it
    i_host.write_word(32'h0600_0007);
    while (ref_in !== 1'b1)
      @(negedge clk);
    ref_run = 1'b0;
    i_host.write_word(32'h1800_0004);
    chk(3'h2, ctrl.probe_mux_sel);
    ref_run = 1'b1;
    while (ref_in !== 1'b0)
      @(negedge clk);
    // A rising-edge load would land only about nine cycles after this
    repeat (6) @(negedge clk);
    chk(3'h3, ctrl.probe_mux_sel);
    $display("t_sync done");
  endtask
  initial
  begin
    reset = 1'b1;
    ok = 1'b0;
    bad = 1'b0;
    ratio = 10'h003;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reg4();
    t_reg6();
    t_dbuf();
    t_lock();
    t_ref();
    t_sync();
    summarize();
  end
endmodule
bind tb_scr_regs scr_regs_asserts #(.RW(10)) i_chk (.clk(clk),
  .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
  .load_strobe(load_strobe), .ref_in(ref_in), .r_count_ratio(ratio),
  .pd_cycle_ok(ok), .pd_cycle_bad(bad), .pd_ref_clk(pd_ref_clk),
  .lock_detect(lock_detect), .reg0_written(reg0_written), .ctrl(ctrl));
`default_nettype wire
